// ===== rtl/link_slot_pkg.sv
// link status and slot capability constants, fields and carriers
// shared by the register logic and its small default memory
package link_slot_pkg;

  localparam logic [7:0] OFS_LINK_STATE = 8'hd0;
  localparam logic [7:0] OFS_SLOT_FEAT  = 8'hd4;
  localparam logic [7:0] OFS_LINK_CTRL  = 8'hd0;

  // link status word fields (upper half of the d0h dword) and the retrain bit 5 of its lower half
  localparam int SPEED_LO    = 16;
  localparam int SPEED_HI    = 19;
  localparam int WIDTH_LO    = 20;
  localparam int WIDTH_HI    = 25;
  localparam int TRAIN_ERR   = 26;
  localparam int TRAIN_BUSY  = 27;
  localparam int SLOT_CLK    = 28;
  localparam int DL_ACTIVE   = 29;
  localparam int RETRAIN_BIT = 5;

  localparam logic [3:0] SPEED_2G5   = 4'h1;
  localparam logic [3:0] SPEED_5G    = 4'h2;
  localparam logic [3:0] SPEED_RESET = 4'h2;
  localparam logic [5:0] WIDTH_RESET = 6'h01;

  // slot capability fields
  localparam int ATTN_BTN    = 0;
  localparam int PWR_CTRL    = 1;
  localparam int ATTN_IND    = 3;
  localparam int PWR_IND     = 4;
  localparam int HP_SURPRISE = 5;
  localparam int HP_CAPABLE  = 6;
  localparam int PLIM_LO     = 7;
  localparam int PLIM_HI     = 14;
  localparam int PSCALE_LO   = 15;
  localparam int PSCALE_HI   = 16;
  localparam int SLOTNUM_LO  = 19;
  localparam int SLOTNUM_HI  = 31;

  localparam logic [7:0]  PLIM_RESET    = 8'h00;
  localparam logic [1:0]  PSCALE_RESET  = 2'h0;
  localparam logic [12:0] SLOTNUM_RESET = 13'h0000;

  // default memory slots for the slot capability word and the link status slot clock bit
  localparam int          DEF_DEPTH     = 4;
  localparam logic [1:0]  DEF_IDX_FLAGS = 2'h0;
  localparam logic [1:0]  DEF_IDX_POWER = 2'h1;
  localparam logic [1:0]  DEF_IDX_SLOT  = 2'h2;
  localparam logic [1:0]  DEF_IDX_CLOCK = 2'h3;

  typedef struct packed {
    logic        train_fail;   // training attempt failed
    logic        train_ok;     // link reached L0
    logic        train_start;  // training begins (any cause)
    logic        dl_active;    // data link state machine in DL_Active
    logic [3:0]  speed;        // negotiated rate code
    logic [5:0]  width;        // negotiated lane count
    logic        speed_valid;  // speed/width update strobe
  } link_event_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic        we;
    logic [1:0]  idx;
    logic [12:0] data;
  } def_load_t;

  typedef enum logic [1:0] {
    LT_IDLE    = 2'b00,
    LT_REQUEST = 2'b01,
    LT_WAIT    = 2'b11
  } retrain_state_t;

endpackage

// ===== rtl/default_store.sv
// small store of slot capability and slot clock defaults written by the autoload path
// assumes the loader writes before software reads; read data is registered
`timescale 1ns/10ps
module default_store
  import link_slot_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH,
  parameter int WIDTH = 13
) (
  input  wire logic                     clk_sys,  // system clock
  input  wire logic                     rst,      // async reset, high
  input  wire logic                     we,       // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr,    // write index
  input  wire logic [WIDTH-1:0]         wdata,    // write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr,    // read index
  output logic      [WIDTH-1:0]         rdata     // registered read data
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  always_comb begin
    next_rdata = mem[raddr];
  end

  // cleared at reset so every field comes up at its zero default
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rdata <= '0;
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= next_rdata;
    end
  end

endmodule // default_store

// ===== rtl/pcie_link_status_slot_caps.sv
// link status and slot capability registers of one switch port
// assumes link events come from the training logic on clk_sys; strap is a pin
`timescale 1ns/10ps

// Summary of operation
// (RL1) link rate in 19:16, reset 5 Gb/s
// (RL2) negotiated lane count 25:20, reset x1
// (RL3) training error set on fail, cleared L0
// (RL4) training flag while training in progress
// (RL5) slot clock bit from strap, autoload override
// (RL6) bit 29 shows DL_Active state
// (RL7) attention button present bit 0
// (RL8) power controller present bit 1
// (RL9) attention indicator present bit 3
// (RL10) power indicator present bit 4
// (RL11) surprise removal allowed bit 5
// (RL12) hot-plug capable bit 6
// (RL13) power limit value, write sends message
// (RL14) power limit scale, write sends message
// (RL15) physical slot number 31:19, reset zero
// (RL16) slot word only on downstream ports
// (RL17) slot defaults loadable by SMBus/EEPROM
// (RL18) retrain starts training on downstream ports, reads back zero
// (RL19) read-only writes ignored, 31:30 zero
module pcie_link_status_slot_caps
  import link_slot_pkg::*;
#(
  parameter bit DOWNSTREAM = 1'b1
) (
  input  wire logic        clk_sys,          // system clock, 50 MHz
  input  wire logic        rst,              // async reset, high
  input  wire cfg_req_t    cfg_req,          // config access request
  output logic      [31:0] cfg_rdata,        // config read data
  input  wire logic [3:0]  cfg_be,           // config byte enables
  input  wire link_event_t link_evt,         // events from training logic
  input  wire logic        slot_clock_strap, // strap pin, asynchronous
  input  wire def_load_t   def_load,         // SMBus/EEPROM default load
  output logic             retrain_req,      // pulse: start retraining
  output logic             power_msg_req,    // pulse: send power limit msg
  output logic      [7:0]  power_msg_value,  // limit value for message
  output logic      [1:0]  power_msg_scale   // limit scale for message
);

  logic [1:0]     strap_sync;
  logic [1:0]     strap_fill;
  logic           strap_seen;
  logic           next_strap_seen;
  logic [3:0]     speed;
  logic [3:0]     next_speed;
  logic [5:0]     width;
  logic [5:0]     next_width;
  logic           train_err;
  logic           next_train_err;
  logic           train_busy;
  logic           next_train_busy;
  logic           dl_up;
  logic           next_dl_up;
  logic           slot_clk;
  logic           next_slot_clk;
  logic [6:0]     feat;
  logic [6:0]     next_feat;
  logic [7:0]     plim;
  logic [7:0]     next_plim;
  logic [1:0]     pscale;
  logic [1:0]     next_pscale;
  logic [12:0]    slot_num;
  logic [12:0]    next_slot_num;
  logic           next_msg;
  logic           next_retrain;
  logic [31:0]    next_rdata;
  logic [31:0]    link_word;
  logic [31:0]    slot_word;
  logic           wr_link;
  logic           wr_slot;
  logic           load_seen;
  logic           next_load_seen;
  logic [1:0]     scan_idx;
  logic [1:0]     next_scan_idx;
  logic [12:0]    def_rdata;
  retrain_state_t rt_state;
  retrain_state_t next_rt_state;

  default_store #(
    .DEPTH (DEF_DEPTH),
    .WIDTH (13)
  ) u_defaults (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (def_load.we),
    .waddr   (def_load.idx),
    .wdata   (def_load.data),
    .raddr   (scan_idx),
    .rdata   (def_rdata)
  );

  // two-stage strap synchroniser, only stage 2 is read
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_sync <= 2'h0;
      strap_fill <= 2'h0;
    end else begin
      strap_sync <= {strap_sync[0], slot_clock_strap};
      // fill marks when stage 2 holds a real pin sample
      strap_fill <= {strap_fill[0], 1'b1};
    end
  end

  assign wr_link = cfg_req.wr && (cfg_req.addr == OFS_LINK_STATE);
  assign wr_slot = cfg_req.wr && (cfg_req.addr == OFS_SLOT_FEAT) && DOWNSTREAM;

  // link status state
  always_comb begin
    next_speed      = speed;
    next_width      = width;
    next_train_err  = train_err;
    next_train_busy = train_busy;
    next_dl_up      = link_evt.dl_active;
    // freeze only once the synchroniser carries the pin, not its reset zero
    next_strap_seen = strap_seen | strap_fill[1];
    next_slot_clk   = slot_clk;
    // (RL1) rate update from training
    if (link_evt.speed_valid) begin
      next_speed = link_evt.speed;
      // (RL2) lane count update
      next_width = link_evt.width;
    end
    // (RL4) busy from start until done
    if (link_evt.train_start || (rt_state == LT_REQUEST)) begin
      next_train_busy = 1'b1;
    end else if (link_evt.train_ok || link_evt.train_fail) begin
      next_train_busy = 1'b0;
    end
    // (RL3) failure wins over L0 clear
    if (link_evt.train_fail) begin
      next_train_err = 1'b1;
    end else if (link_evt.train_ok) begin
      next_train_err = 1'b0;
    end
    // (RL5) strap caught once after release
    if (!strap_seen) begin
      next_slot_clk = strap_sync[1];
    end
    // (RL5) autoload override of clock bit
    // store output lags the scan index by one
    if (load_seen && (scan_idx - 2'h1) == DEF_IDX_CLOCK) begin
      next_slot_clk = def_rdata[0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speed      <= SPEED_RESET;
      width      <= WIDTH_RESET;
      train_err  <= 1'b0;
      train_busy <= 1'b0;
      dl_up      <= 1'b0;
      strap_seen <= 1'b0;
      slot_clk   <= 1'b0;
    end else begin
      speed      <= next_speed;
      width      <= next_width;
      train_err  <= next_train_err;
      train_busy <= next_train_busy;
      // (RL6) follows DL_Active directly
      dl_up      <= next_dl_up;
      strap_seen <= next_strap_seen;
      slot_clk   <= next_slot_clk;
    end
  end

  // (RL18) retrain handshake, downstream only
  always_comb begin
    next_rt_state = rt_state;
    next_retrain  = 1'b0;
    unique case (rt_state)
      LT_IDLE: begin
        if (wr_link && DOWNSTREAM && cfg_be[0] && cfg_req.wdata[RETRAIN_BIT]) begin
          next_rt_state = LT_REQUEST;
        end
      end
      LT_REQUEST: begin
        next_retrain  = 1'b1;
        next_rt_state = LT_WAIT;
      end
      LT_WAIT: begin
        if (link_evt.train_ok || link_evt.train_fail) begin
          next_rt_state = LT_IDLE;
        end
      end
      default: next_rt_state = LT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rt_state    <= LT_IDLE;
      retrain_req <= 1'b0;
    end else begin
      rt_state    <= next_rt_state;
      retrain_req <= next_retrain;
    end
  end

  // default scan: walks the store continuously from reset so new defaults apply
  always_comb begin
    next_scan_idx  = scan_idx + 2'h1;
    next_load_seen = load_seen;
    if (def_load.we) begin
      next_load_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scan_idx  <= 2'h0;
      load_seen <= 1'b0;
    end else begin
      scan_idx  <= next_scan_idx;
      load_seen <= next_load_seen;
    end
  end

  // slot capability state; def_rdata lags scan_idx by one cycle
  always_comb begin
    next_feat     = feat;
    next_plim     = plim;
    next_pscale   = pscale;
    next_slot_num = slot_num;
    next_msg      = 1'b0;
    // (RL17) apply loaded defaults
    if (load_seen && DOWNSTREAM) begin
      unique case (scan_idx - 2'h1)
        // (RL7) flags 0..6 from store
        DEF_IDX_FLAGS: next_feat = def_rdata[6:0];
        DEF_IDX_POWER: begin
          next_plim   = def_rdata[7:0];
          next_pscale = def_rdata[9:8];
        end
        // (RL15) slot number default
        DEF_IDX_SLOT:  next_slot_num = def_rdata;
        DEF_IDX_CLOCK: next_slot_num = slot_num;
      endcase
    end
    // (RL13) value write sends message
    if (wr_slot && cfg_be[0] && cfg_be[1]) begin
      next_plim = cfg_req.wdata[PLIM_HI:PLIM_LO];
      next_msg  = 1'b1;
    end
    // (RL14) scale write sends message
    if (wr_slot && cfg_be[1] && cfg_be[2]) begin
      next_pscale = cfg_req.wdata[PSCALE_HI:PSCALE_LO];
      next_msg    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      feat            <= 7'h00;
      plim            <= PLIM_RESET;
      pscale          <= PSCALE_RESET;
      slot_num        <= SLOTNUM_RESET;
      power_msg_req   <= 1'b0;
      power_msg_value <= PLIM_RESET;
      power_msg_scale <= PSCALE_RESET;
    end else begin
      feat            <= next_feat;
      plim            <= next_plim;
      pscale          <= next_pscale;
      slot_num        <= next_slot_num;
      power_msg_req   <= next_msg;
      power_msg_value <= next_plim;
      power_msg_scale <= next_pscale;
    end
  end

  // (RL19) reserved bits zero, retrain reads zero
  always_comb begin
    link_word                        = '0;
    link_word[SPEED_HI:SPEED_LO]     = speed;
    link_word[WIDTH_HI:WIDTH_LO]     = width;
    link_word[TRAIN_ERR]             = train_err;
    link_word[TRAIN_BUSY]            = train_busy;
    link_word[SLOT_CLK]              = slot_clk;
    link_word[DL_ACTIVE]             = dl_up;
    slot_word                        = '0;
    // (RL8) feature bits with bit 2 reserved
    slot_word[ATTN_BTN]              = feat[ATTN_BTN];
    slot_word[PWR_CTRL]              = feat[PWR_CTRL];
    // (RL9) attention indicator
    slot_word[ATTN_IND]              = feat[ATTN_IND];
    // (RL10) power indicator
    slot_word[PWR_IND]               = feat[PWR_IND];
    // (RL11) surprise removal
    slot_word[HP_SURPRISE]           = feat[HP_SURPRISE];
    // (RL12) hot-plug capable
    slot_word[HP_CAPABLE]            = feat[HP_CAPABLE];
    slot_word[PLIM_HI:PLIM_LO]       = plim;
    slot_word[PSCALE_HI:PSCALE_LO]   = pscale;
    slot_word[SLOTNUM_HI:SLOTNUM_LO] = slot_num;
    next_rdata                       = cfg_rdata;
    if (cfg_req.rd) begin
      next_rdata = 32'h0000_0000;
      if (cfg_req.addr == OFS_LINK_STATE) begin
        next_rdata = link_word;
      end else if (cfg_req.addr == OFS_SLOT_FEAT && DOWNSTREAM) begin
        // (RL16) upstream reads zero here
        next_rdata = slot_word;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_rdata <= next_rdata;
    end
  end

endmodule // pcie_link_status_slot_caps

// ===== verif/link_slot_props.sv
// assertions on the port behaviour of the link status / slot capability block
// bound to every instance; sees only the block's ports
`timescale 1ns/10ps
module link_slot_props
  import link_slot_pkg::*;
#(
  parameter bit DOWNSTREAM = 1'b1
) (
  input wire logic        clk_sys,         // system clock
  input wire logic        rst,             // async reset, high
  input wire cfg_req_t    cfg_req,         // config request
  input wire logic [3:0]  cfg_be,          // byte enables
  input wire logic [31:0] cfg_rdata,       // read data
  input wire link_event_t link_evt,        // training events
  input wire logic        retrain_req,     // retrain pulse
  input wire logic        power_msg_req,   // message pulse
  input wire logic [7:0]  power_msg_value, // message value
  input wire logic [1:0]  power_msg_scale  // message scale
);
  wire wr_d4 = cfg_req.wr && cfg_req.addr == 8'hd4;
  wire wr_d0 = cfg_req.wr && cfg_req.addr == 8'hd0;
  wire rd_d4 = cfg_req.rd && cfg_req.addr == 8'hd4;
  wire rd_d0 = cfg_req.rd && cfg_req.addr == 8'hd0;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_MSG_ON_WR: assert property (DOWNSTREAM && wr_d4 && cfg_be[1] && (cfg_be[0] || cfg_be[2]) |=> power_msg_req)
    else $error("no power message after limit write");
  AST_MSG_FIELDS: assert property (DOWNSTREAM && wr_d4 && cfg_be == 4'hf |=>
    power_msg_value == $past(cfg_req.wdata[14:7]) && power_msg_scale == $past(cfg_req.wdata[16:15]))
    else $error("power message fields differ from write");
  AST_MSG_CAUSE: assert property (power_msg_req |-> $past(wr_d4 && cfg_be[1]))
    else $error("power message without limit write");
  AST_NO_MSG_UP: assert property (!DOWNSTREAM |-> !power_msg_req)
    else $error("upstream port sent power message");
  AST_UP_SLOT_ZERO: assert property (!DOWNSTREAM && rd_d4 |=> cfg_rdata == 32'h0)
    else $error("upstream slot word not zero");
  AST_RETRAIN_CAUSE: assert property (retrain_req |-> $past(wr_d0 && cfg_be[0] && cfg_req.wdata[5], 2))
    else $error("retrain pulse without retrain write");
  AST_RETRAIN_PULSE: assert property (retrain_req |=> !retrain_req)
    else $error("retrain pulse longer than one cycle");
  AST_LINK_RSVD: assert property (rd_d0 |=> cfg_rdata[31:30] == 2'b00 && !cfg_rdata[5])
    else $error("link word reserved or retrain bit set");
  AST_SLOT_RSVD: assert property (rd_d4 |=> cfg_rdata[18:17] == 2'b00 && !cfg_rdata[2])
    else $error("slot word reserved bits set");
  AST_DL_ACTIVE: assert property (rd_d0 && $stable(link_evt.dl_active) |=>
    cfg_rdata[29] == $past(link_evt.dl_active))
    else $error("link active bit differs from state");

  cover property (power_msg_req);
  cover property (retrain_req);
  cover property (rd_d0 ##1 cfg_rdata[27]);
endmodule // link_slot_props

bind pcie_link_status_slot_caps link_slot_props #(.DOWNSTREAM(DOWNSTREAM)) u_link_slot_props (
  .clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
  .link_evt(link_evt), .retrain_req(retrain_req), .power_msg_req(power_msg_req),
  .power_msg_value(power_msg_value), .power_msg_scale(power_msg_scale));

// ===== verif/link_partner.sv
// behavioural training logic and link partner facing one switch port
// answers a retrain after wait_cyc cycles, failing when fail_next is high
`timescale 1ns/10ps
module link_partner
  import link_slot_pkg::*;
(
  input  wire logic  clk_sys,         // system clock
  input  wire logic  rst,             // async reset, high
  input  wire logic  retrain_req,     // retrain pulse from port
  input  wire logic  power_msg_req,   // message pulse from port
  input  wire logic [7:0] power_msg_value, // message value
  input  wire logic [1:0] power_msg_scale, // message scale
  input  wire logic  fail_next,       // next training fails
  input  wire logic [7:0] wait_cyc,   // training length
  output link_event_t link_evt,       // events to the port
  output logic [7:0] msg_value,       // last message value
  output logic [1:0] msg_scale,       // last message scale
  output int         msg_cnt          // messages seen
);
  logic [7:0] cnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_evt  <= '0;
      cnt       <= 8'h00;
      msg_value <= 8'h00;
      msg_scale <= 2'h0;
      msg_cnt   <= 0;
    end else begin
      link_evt.train_start <= retrain_req;
      link_evt.train_ok    <= 1'b0;
      link_evt.train_fail  <= 1'b0;
      link_evt.speed_valid <= 1'b0;
      if (retrain_req) begin
        cnt                <= wait_cyc;
        link_evt.dl_active <= 1'b0;
      end else if (cnt == 8'h01) begin
        cnt <= 8'h00;
        if (fail_next) begin
          link_evt.train_fail <= 1'b1;
        end else begin
          link_evt.train_ok    <= 1'b1;
          link_evt.dl_active   <= 1'b1;
          link_evt.speed_valid <= 1'b1;
          link_evt.speed       <= SPEED_2G5;
          link_evt.width       <= 6'h04;
        end
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      if (power_msg_req) begin
        msg_value <= power_msg_value;
        msg_scale <= power_msg_scale;
        msg_cnt   <= msg_cnt + 1;
      end
    end
  end
endmodule // link_partner

// ===== verif/tb_top.sv
// self-checking bench: downstream port with partner, upstream port alongside
// assumes the partner model and the bound checker are compiled before it
`timescale 1ns/10ps
module tb_top;
  import link_slot_pkg::*;
  logic        clk_sys, rst, slot_clock_strap, fail_next;
  logic        retrain_req, power_msg_req;
  logic [3:0]  cfg_be;
  logic [7:0]  power_msg_value, msg_value, wait_cyc;
  logic [1:0]  power_msg_scale, msg_scale;
  logic [31:0] cfg_rdata, rdata_up, r, ru;
  cfg_req_t    cfg_req;
  def_load_t   def_load;
  link_event_t link_evt;
  int          msg_cnt, n_retrain, n_mismatch, num_checks, cyc;
  logic [12:0] dv [4] = '{13'h007b, 13'h02c3, 13'h1abd, 13'h0000};

  pcie_link_status_slot_caps #(.DOWNSTREAM(1'b1)) u_pcie_link_status_slot_caps (.clk_sys(clk_sys), .rst(rst),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_be(cfg_be), .link_evt(link_evt),
    .slot_clock_strap(slot_clock_strap), .def_load(def_load), .retrain_req(retrain_req),
    .power_msg_req(power_msg_req), .power_msg_value(power_msg_value), .power_msg_scale(power_msg_scale));
  pcie_link_status_slot_caps #(.DOWNSTREAM(1'b0)) u_pcie_link_status_slot_caps_up (.clk_sys(clk_sys), .rst(rst),
    .cfg_req(cfg_req), .cfg_rdata(rdata_up), .cfg_be(cfg_be), .link_evt(link_evt),
    .slot_clock_strap(slot_clock_strap), .def_load(def_load), .retrain_req(),
    .power_msg_req(), .power_msg_value(), .power_msg_scale());
  link_partner u_link_partner (.clk_sys(clk_sys), .rst(rst), .retrain_req(retrain_req),
    .power_msg_req(power_msg_req), .power_msg_value(power_msg_value), .power_msg_scale(power_msg_scale),
    .fail_next(fail_next), .wait_cyc(wait_cyc), .link_evt(link_evt), .msg_value(msg_value),
    .msg_scale(msg_scale), .msg_cnt(msg_cnt));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // whole run is about 120 cycles; ceiling well above
  always @(posedge clk_sys) begin
    cyc++;
    if (retrain_req === 1'b1) n_retrain++;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task cyc_wait(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    cfg_req.wr    = 1'b1;
    cfg_req.addr  = a;
    cfg_req.wdata = d;
    cfg_be        = be;
    cyc_wait(1);
    cfg_req.wr = 1'b0;
  endtask

  task rd(input logic [7:0] a);
    cfg_req.rd   = 1'b1;
    cfg_req.addr = a;
    cyc_wait(1);
    cfg_req.rd = 1'b0;
    cyc_wait(1);
    r  = cfg_rdata;
    ru = rdata_up;
  endtask

  task t_reset;
    rd(8'hd0);
    chk(r & 32'hffff0020, 32'h10120000);
    rd(8'hd4);
    chk(r, 32'h00000000);
    chk(ru, 32'h00000000);
    rd(8'hd8);
    chk(r, 32'h00000000);
  endtask

  task t_limit;
    wr(8'hd4, 32'hfffed2ff, 4'hf);
    cyc_wait(2);
    chk(msg_cnt, 1);
    chk({22'h0, msg_scale, msg_value}, 32'h000001a5);
    rd(8'hd4);
    chk(r, 32'h0000d280);
    chk(ru, 32'h00000000);
    // top byte only: no limit field touched, so no message
    wr(8'hd4, 32'hfff80000, 4'h8);
    cyc_wait(2);
    chk(msg_cnt, 1);
    rd(8'hd4);
    chk(r, 32'h0000d280);
  endtask

  task t_retrain;
    n_retrain = 0;
    wr(8'hd0, 32'hffff0020, 4'hf);
    cyc_wait(2);
    rd(8'hd0);
    chk(r & 32'hffff0020, 32'h18120000);
    // second request while pending must not retrigger
    wr(8'hd0, 32'h00000020, 4'h1);
    cyc_wait(20);
    rd(8'hd0);
    chk(r & 32'hffff0020, 32'h30410000);
    chk(n_retrain, 1);
    fail_next = 1'b1;
    wait_cyc  = 8'h03;
    wr(8'hd0, 32'h00000020, 4'h1);
    cyc_wait(20);
    rd(8'hd0);
    chk(r & 32'hffff0020, 32'h14410000);
    fail_next = 1'b0;
    wr(8'hd0, 32'h00000020, 4'h1);
    cyc_wait(20);
    rd(8'hd0);
    chk(r & 32'hffff0020, 32'h30410000);
  endtask

  task t_autoload;
    for (int i = 0; i < 4; i++) begin
      def_load = '{1'b1, 2'(i), dv[i]};
      cyc_wait(1);
    end
    def_load.we = 1'b0;
    cyc_wait(12);
    rd(8'hd4);
    chk(r, 32'hd5e961fb);
    chk(ru, 32'h00000000);
    rd(8'hd0);
    chk(r & 32'h10000000, 32'h00000000);
  endtask

  initial begin
    rst              = 1'b1;
    cfg_req          = '0;
    cfg_be           = 4'h0;
    def_load         = '0;
    slot_clock_strap = 1'b1;
    fail_next        = 1'b0;
    wait_cyc         = 8'h08;
    n_mismatch       = 0;
    num_checks       = 0;
    n_retrain        = 0;
    cyc              = 0;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    // strap lands at the third edge after release
    cyc_wait(3);
    t_reset;
    t_limit;
    t_retrain;
    t_autoload;
    test_done;
  end
endmodule // tb_top
